// ==== rtl/gcpl_pkg.sv ====
// Constants for the global configuration power and lock register bank
// Overview of operation
// - Config registers reachable only in config state via index
// - Valid register bits 0-6 read fixed, bit 5 one
// - Valid bit is software flag without hardware effect
// - Power-on reset loads valid register with 0x20
// - Power-on 0x9C; hard reset forces lock bit one
// - Reserved bits read zero, parallel bit 4 one
// - Parallel power bit set powers port, clear sleeps
// - Parallel mode bit: printer, else misc register modes
// - Lock bit zero blocks access to indices 0x00-0x39
// - Cleared lock cannot be set by software
// - Serial power bit clear powers down serial port
// - Power-on 0x08; hard reset leaves the serial register unchanged
// - Power bit gates pins, never address decoding
// - Base address below 0x100 stops host decoding
// - Powered-down device still joins range checking
// - Index 0x03 reserved, reads return zero
// - Host bus reset pin acts as hard reset
package gcpl_pkg;
	// Wishbone byte offsets of the software window
	localparam logic [7:0] WB_CTRL = 8'h00;
	localparam logic [7:0] WB_INDEX = 8'h04;
	localparam logic [7:0] WB_DATA = 8'h08;
	localparam logic [7:0] WB_STATUS = 8'h0c;
	localparam int WB_DW = 32;
	localparam int WB_AW = 8;

	// Control and status bit positions
	localparam int CTRL_CFG_STATE_BIT = 0;
	localparam int STAT_CFG_STATE_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_PPORT_PWR_BIT = 2;
	localparam int STAT_SERIAL_PWR_BIT = 3;
	localparam int STAT_PPORT_DEC_BIT = 4;
	localparam int STAT_SERIAL_DEC_BIT = 5;

	// Configuration indices
	localparam logic [7:0] IDX_VALID = 8'h00;
	localparam logic [7:0] IDX_PPORT = 8'h01;
	localparam logic [7:0] IDX_SERIAL = 8'h02;
	localparam logic [7:0] IDX_RSVD3 = 8'h03;
	localparam logic [7:0] IDX_LOCK_LAST = 8'h39;

	// Field positions
	localparam int VALID_FLAG_BIT = 7;
	localparam int PPORT_POWER_BIT = 2;
	localparam int PPORT_MODE_BIT = 3;
	localparam int PPORT_LOCK_BIT = 7;
	localparam int SERIAL_POWER_BIT = 3;

	// Power-on values and fixed read patterns
	localparam logic [7:0] VALID_POR = 8'h20;
	localparam logic [7:0] PPORT_POR = 8'h9c;
	localparam logic [7:0] SERIAL_POR = 8'h08;
	localparam logic [7:0] VALID_FIXED = 8'h20;
	localparam logic [7:0] PPORT_FIXED = 8'h10;
	localparam logic [7:0] SERIAL_FIXED = 8'h00;
	localparam logic [7:0] RSVD_READ = 8'h00;

	// Lowest base address that the host decoder accepts
	localparam logic [15:0] BASE_MIN = 16'h0100;
	localparam int SYNC_STAGES = 2;
endpackage

// ==== rtl/gcpl_sync.sv ====
// Two-stage level synchroniser for the host bus reset pin
`timescale 1ns/1ps
`default_nettype none
module gcpl_sync (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pin_in,
	output logic pin_sync
);
	logic [gcpl_pkg::SYNC_STAGES-1:0] stage;

	// Resets to one: the pin is active low, so idle is high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage <= '1;
		end else begin
			stage <= {stage[gcpl_pkg::SYNC_STAGES-2:0], pin_in};
		end
	end

	// Only the last stage is seen outside
	assign pin_sync = stage[gcpl_pkg::SYNC_STAGES-1];
endmodule
`default_nettype wire

// ==== rtl/gcpl_regs.sv ====
// Global configuration power and lock registers behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module gcpl_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic host_bus_reset_n,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [gcpl_pkg::WB_AW-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [gcpl_pkg::WB_DW-1:0] wb_dat_w,
	output logic [gcpl_pkg::WB_DW-1:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [1:0] misc_mode_register,
	input wire logic [15:0] pport_base_addr,
	input wire logic [15:0] serial_base_addr,
	output logic pport_pins_en,
	output logic pport_printer_mode,
	output logic [1:0] pport_ext_mode,
	output logic serial_pins_en,
	output logic pport_decode_en,
	output logic serial_decode_en,
	output logic pport_pnp_check,
	output logic serial_pnp_check
);
	// Stored state
	logic config_state;
	logic [7:0] config_index_select;
	logic valid_flag;
	logic pport_power;
	logic pport_mode;
	logic register_lock;
	logic serial_power;

	// Hard reset from the host bus pin
	logic host_reset_sync;
	wire hard_reset;

	gcpl_sync u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(host_bus_reset_n),
		.pin_sync(host_reset_sync)
	);

	assign hard_reset = ~host_reset_sync;

	// Gate for the indexed data port, shared by read and write
	function automatic logic cfg_open(input logic [7:0] idx, input logic state,
		input logic lock);
		cfg_open = state && lock && (idx <= gcpl_pkg::IDX_LOCK_LAST);
	endfunction

	// Byte seen at a configuration index
	function automatic logic [7:0] cfg_byte(input logic [7:0] idx, input logic v,
		input logic pw, input logic md, input logic lk, input logic sp);
		logic [7:0] b;
		b = gcpl_pkg::RSVD_READ;
		unique case (idx)
			gcpl_pkg::IDX_VALID: begin
				b = gcpl_pkg::VALID_FIXED;
				b[gcpl_pkg::VALID_FLAG_BIT] = v;
			end
			gcpl_pkg::IDX_PPORT: begin
				b = gcpl_pkg::PPORT_FIXED;
				b[gcpl_pkg::PPORT_POWER_BIT] = pw;
				b[gcpl_pkg::PPORT_MODE_BIT] = md;
				b[gcpl_pkg::PPORT_LOCK_BIT] = lk;
			end
			gcpl_pkg::IDX_SERIAL: begin
				b = gcpl_pkg::SERIAL_FIXED;
				b[gcpl_pkg::SERIAL_POWER_BIT] = sp;
			end
			// Index 3 and the rest of the locked range read as zero
			default: b = gcpl_pkg::RSVD_READ;
		endcase
		cfg_byte = b;
	endfunction

	// Bus decode
	wire req = wb_cyc && wb_stb;
	wire aligned = (wb_adr[1:0] == 2'b00);
	wire hit_ctrl = aligned && (wb_adr == gcpl_pkg::WB_CTRL);
	wire hit_index = aligned && (wb_adr == gcpl_pkg::WB_INDEX);
	wire hit_data = aligned && (wb_adr == gcpl_pkg::WB_DATA);
	wire hit_status = aligned && (wb_adr == gcpl_pkg::WB_STATUS);
	wire lane0 = wb_sel[0];

	// Writes commit on the edge where the master sees ack
	wire wr_fire = req && wb_we && wb_ack && lane0;
	wire wr_ctrl = wr_fire && hit_ctrl;
	wire wr_index = wr_fire && hit_index;
	wire data_open = cfg_open(config_index_select, config_state, register_lock);
	wire wr_cfg = wr_fire && hit_data && data_open;
	wire wr_valid = wr_cfg && (config_index_select == gcpl_pkg::IDX_VALID);
	wire wr_pport = wr_cfg && (config_index_select == gcpl_pkg::IDX_PPORT);
	wire wr_serial = wr_cfg && (config_index_select == gcpl_pkg::IDX_SERIAL);
	wire [7:0] wbyte = wb_dat_w[7:0];

	// Read data latched when ack rises, before any write lands
	wire rd_start = req && !wb_we && !wb_ack;
	wire [7:0] cfg_now = cfg_byte(config_index_select, valid_flag, pport_power,
		pport_mode, register_lock, serial_power);
	wire [7:0] data_read = data_open ? cfg_now : gcpl_pkg::RSVD_READ;
	wire [7:0] status_read;
	assign status_read = {2'b00, serial_decode_en, pport_decode_en, serial_power,
		pport_power, register_lock, config_state};
	wire [7:0] ctrl_read = {7'b000_0000, config_state};
	wire [7:0] next_rd_byte = hit_ctrl ? ctrl_read :
		hit_index ? config_index_select :
		hit_data ? data_read :
		hit_status ? status_read : gcpl_pkg::RSVD_READ;

	// Next values of the configuration fields
	wire next_lock = hard_reset ? 1'b1 :
		wr_pport ? (register_lock & wbyte[gcpl_pkg::PPORT_LOCK_BIT]) :
		register_lock;
	wire next_pport_power = wr_pport ? wbyte[gcpl_pkg::PPORT_POWER_BIT] : pport_power;
	wire next_pport_mode = wr_pport ? wbyte[gcpl_pkg::PPORT_MODE_BIT] : pport_mode;
	wire next_serial_power = wr_serial ? wbyte[gcpl_pkg::SERIAL_POWER_BIT] :
		serial_power;
	wire next_valid = wr_valid ? wbyte[gcpl_pkg::VALID_FLAG_BIT] : valid_flag;

	// Decoding stays on while the device is powered down
	wire next_pport_dec = (pport_base_addr >= gcpl_pkg::BASE_MIN);
	wire next_serial_dec = (serial_base_addr >= gcpl_pkg::BASE_MIN);
	wire [1:0] next_ext_mode = pport_mode ? 2'b00 : misc_mode_register;

	// Bus handshake
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_ack <= 1'b0;
			wb_dat_r <= '0;
		end else begin
			wb_ack <= req && !wb_ack;
			if (rd_start) begin
				wb_dat_r <= {24'h0000_00, next_rd_byte};
			end
		end
	end

	// Software window control
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			config_state <= 1'b0;
			config_index_select <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				config_state <= wbyte[gcpl_pkg::CTRL_CFG_STATE_BIT];
			end
			if (wr_index) begin
				config_index_select <= wbyte;
			end
		end
	end

	// Only writable fields are stored; reserved bits never change
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_flag <= gcpl_pkg::VALID_POR[gcpl_pkg::VALID_FLAG_BIT];
			pport_power <= gcpl_pkg::PPORT_POR[gcpl_pkg::PPORT_POWER_BIT];
			pport_mode <= gcpl_pkg::PPORT_POR[gcpl_pkg::PPORT_MODE_BIT];
			register_lock <= gcpl_pkg::PPORT_POR[gcpl_pkg::PPORT_LOCK_BIT];
			serial_power <= gcpl_pkg::SERIAL_POR[gcpl_pkg::SERIAL_POWER_BIT];
		end else begin
			valid_flag <= next_valid;
			pport_power <= next_pport_power;
			pport_mode <= next_pport_mode;
			register_lock <= next_lock;
			serial_power <= next_serial_power;
		end
	end

	// Device control outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pport_pins_en <= gcpl_pkg::PPORT_POR[gcpl_pkg::PPORT_POWER_BIT];
			pport_printer_mode <= gcpl_pkg::PPORT_POR[gcpl_pkg::PPORT_MODE_BIT];
			pport_ext_mode <= 2'b00;
			serial_pins_en <= gcpl_pkg::SERIAL_POR[gcpl_pkg::SERIAL_POWER_BIT];
			pport_decode_en <= 1'b0;
			serial_decode_en <= 1'b0;
			pport_pnp_check <= 1'b0;
			serial_pnp_check <= 1'b0;
		end else begin
			pport_pins_en <= pport_power;
			pport_printer_mode <= pport_mode;
			pport_ext_mode <= next_ext_mode;
			serial_pins_en <= serial_power;
			pport_decode_en <= next_pport_dec;
			serial_decode_en <= next_serial_dec;
			pport_pnp_check <= next_pport_dec;
			serial_pnp_check <= next_serial_dec;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	logic past_rst;
	always_ff @(posedge clk_sys) begin
		past_rst <= rst;
	end

	lock_sticky_a: assert property (
		!register_lock && !hard_reset |=> !register_lock)
		else $error("lock bit was set again by software");

	hard_lock_a: assert property (
		hard_reset && !wr_cfg |=> register_lock && $stable(pport_power) && $stable(serial_power))
		else $error("hard reset did not force only the lock bit");

	por_values_a: assert property (
		past_rst |-> cfg_byte(gcpl_pkg::IDX_VALID, valid_flag, pport_power,
			pport_mode, register_lock, serial_power) == gcpl_pkg::VALID_POR &&
		cfg_byte(gcpl_pkg::IDX_PPORT, valid_flag, pport_power, pport_mode,
			register_lock, serial_power) == gcpl_pkg::PPORT_POR &&
		cfg_byte(gcpl_pkg::IDX_SERIAL, valid_flag, pport_power, pport_mode,
			register_lock, serial_power) == gcpl_pkg::SERIAL_POR)
		else $error("power-on values wrong");

	fixed_bits_a: assert property (
		rd_start && hit_data && data_open && config_index_select == gcpl_pkg::IDX_PPORT
		|=> (wb_dat_r[7:0] & 8'h73) == gcpl_pkg::PPORT_FIXED)
		else $error("parallel reserved bits read wrong");

	rsvd_index_a: assert property (
		rd_start && hit_data && config_index_select == gcpl_pkg::IDX_RSVD3
		|=> wb_dat_r == '0)
		else $error("reserved index did not read zero");

	locked_read_a: assert property (
		rd_start && hit_data && !register_lock |=> wb_dat_r == '0)
		else $error("locked range was readable");

	no_cfg_write_a: assert property (
		wr_fire && hit_data && !config_state |=>
		$stable(pport_power) && $stable(valid_flag) && $stable(serial_power))
		else $error("config write outside config state");

	pins_follow_a: assert property (
		##1 pport_pins_en == $past(pport_power) && serial_pins_en == $past(serial_power))
		else $error("pin enable does not follow power bit");

	decode_keep_a: assert property (
		!pport_power && pport_base_addr >= gcpl_pkg::BASE_MIN && $stable(pport_base_addr)
		|=> pport_decode_en && pport_pnp_check)
		else $error("powered-down port stopped decoding");

	ack_pulse_a: assert property (
		req && !wb_ack |=> wb_ack ##1 !wb_ack)
		else $error("ack not a one-cycle answer");

	// Read data stands until the next read is taken
	rd_hold_a: assert property (
		!rd_start |=> $stable(wb_dat_r))
		else $error("read data changed without a read");

	ack_idle_a: assert property (
		!req |=> !wb_ack)
		else $error("ack without a request");

	cfg_state_a: assert property (
		wr_ctrl |=> config_state == $past(wbyte[gcpl_pkg::CTRL_CFG_STATE_BIT]))
		else $error("config state did not take the written bit");

	index_gate_a: assert property (
		wr_fire && hit_data && config_index_select != gcpl_pkg::IDX_PPORT
		|=> $stable(pport_power) && $stable(pport_mode))
		else $error("parallel fields written through another index");

	valid_fixed_a: assert property (
		rd_start && hit_data && data_open && config_index_select == gcpl_pkg::IDX_VALID
		|=> wb_dat_r[gcpl_pkg::VALID_FLAG_BIT-1:0] ==
		gcpl_pkg::VALID_FIXED[gcpl_pkg::VALID_FLAG_BIT-1:0])
		else $error("valid register fixed bits read wrong");

	valid_flag_a: assert property (
		wr_valid |=> valid_flag == $past(wbyte[gcpl_pkg::VALID_FLAG_BIT]))
		else $error("valid flag did not take the written bit");

	valid_free_a: assert property (
		wr_valid && !hard_reset |=> $stable(pport_power) && $stable(pport_mode) &&
		$stable(register_lock) && $stable(serial_power))
		else $error("valid flag touched other hardware");

	serial_fixed_a: assert property (
		rd_start && hit_data && data_open && config_index_select == gcpl_pkg::IDX_SERIAL
		|=> wb_dat_r[7:gcpl_pkg::SERIAL_POWER_BIT+1] == '0 &&
		wb_dat_r[gcpl_pkg::SERIAL_POWER_BIT-1:0] == '0)
		else $error("serial reserved bits read wrong");

	pport_power_a: assert property (
		wr_pport |-> ##2 pport_pins_en == $past(wbyte[gcpl_pkg::PPORT_POWER_BIT], 2))
		else $error("parallel pins do not follow the power bit");

	pport_mode_a: assert property (
		wr_pport |-> ##2 pport_printer_mode == $past(wbyte[gcpl_pkg::PPORT_MODE_BIT], 2))
		else $error("printer mode does not follow the mode bit");

	ext_mode_a: assert property (
		##1 pport_ext_mode == ($past(pport_mode) ? 2'b00 : $past(misc_mode_register)))
		else $error("extended mode select wrong");

	serial_power_a: assert property (
		wr_serial |-> ##2 serial_pins_en == $past(wbyte[gcpl_pkg::SERIAL_POWER_BIT], 2))
		else $error("serial pins do not follow the power bit");

	hard_serial_a: assert property (
		hard_reset && !wr_cfg |=> $stable(serial_power) && $stable(valid_flag))
		else $error("hard reset changed the serial register");

	pnp_range_a: assert property (
		##1 pport_pnp_check == ($past(pport_base_addr) >= gcpl_pkg::BASE_MIN) &&
		serial_pnp_check == ($past(serial_base_addr) >= gcpl_pkg::BASE_MIN))
		else $error("range checking does not follow the base address");

	decode_off_a: assert property (
		##1 serial_decode_en == ($past(serial_base_addr) >= gcpl_pkg::BASE_MIN))
		else $error("serial decode does not follow the base address");

	hard_pin_a: assert property (
		!host_bus_reset_n [*3] |=> register_lock)
		else $error("host bus reset did not restore the lock bit");

	rsvd_write_a: assert property (
		wr_fire && hit_data && !hard_reset && config_index_select == gcpl_pkg::IDX_RSVD3
		|=> $stable(valid_flag) && $stable(pport_power) && $stable(pport_mode) &&
		$stable(serial_power) && $stable(register_lock))
		else $error("reserved index write changed a register");

	locked_write_a: assert property (
		wr_fire && hit_data && !register_lock |=> $stable(valid_flag) &&
		$stable(pport_power) && $stable(pport_mode) && $stable(serial_power))
		else $error("locked range was writable");

	high_index_a: assert property (
		rd_start && hit_data && config_index_select > gcpl_pkg::IDX_LOCK_LAST
		|=> wb_dat_r == '0)
		else $error("index above the locked range was readable");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the global config power and lock register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic host_bus_reset_n = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [gcpl_pkg::WB_AW-1:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [gcpl_pkg::WB_DW-1:0] wb_dat_w = 32'h0000_0000;
	logic [gcpl_pkg::WB_DW-1:0] wb_dat_r;
	logic wb_ack;
	logic [1:0] misc_mode_register = 2'h0;
	logic [15:0] pport_base_addr = 16'h0000;
	logic [15:0] serial_base_addr = 16'h0000;
	logic pport_pins_en, pport_printer_mode, serial_pins_en;
	logic [1:0] pport_ext_mode;
	logic pport_decode_en, serial_decode_en, pport_pnp_check, serial_pnp_check;
	integer errors = 0;
	integer compares = 0;
	integer seed = 32'hfca9_1974;
	integer i;
	logic [31:0] rd;
	logic [7:0] w, p;

	gcpl_regs dut (.clk_sys(clk_sys), .rst(rst), .host_bus_reset_n(host_bus_reset_n),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.misc_mode_register(misc_mode_register), .pport_base_addr(pport_base_addr),
		.serial_base_addr(serial_base_addr), .pport_pins_en(pport_pins_en),
		.pport_printer_mode(pport_printer_mode), .pport_ext_mode(pport_ext_mode),
		.serial_pins_en(serial_pins_en), .pport_decode_en(pport_decode_en),
		.serial_decode_en(serial_decode_en), .pport_pnp_check(pport_pnp_check),
		.serial_pnp_check(serial_pnp_check));

	always #2 clk_sys = ~clk_sys;

	function automatic logic [7:0] exp_valid(input logic [7:0] d);
		return {d[7], 7'h20};
	endfunction
	// Lock only follows a write of zero; software can never raise it
	function automatic logic [7:0] exp_pport(input logic [7:0] d, input logic lk);
		return {lk & d[7], 3'b001, d[3], d[2], 2'b00};
	endfunction
	function automatic logic [7:0] exp_serial(input logic [7:0] d);
		return {4'h0, d[3], 3'b000};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; holds everything until ack is seen on a rising edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat_w <= d;
		@(posedge clk_sys);
		while (wb_ack !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n = n + 1;
		end
		if (n == 20) begin
			errors = errors + 1;
			$display("wrong value at %0t: no acknowledge", $time);
		end
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, gcpl_pkg::WB_INDEX, {24'h0, idx});
		bus(1'b1, gcpl_pkg::WB_DATA, {24'h0, d});
	endtask

	task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b1, gcpl_pkg::WB_INDEX, {24'h0, idx});
		bus(1'b0, gcpl_pkg::WB_DATA, 32'h0000_0000);
		chk(rd, {24'h0, exp});
	endtask

	task automatic tdone(input string name);
		$display("test %s done at %0t", name, $time);
	endtask

	task automatic print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#100000;
		errors = errors + 1;
		$display("wrong value at %0t: run timed out", $time);
		print_verdict;
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, gcpl_pkg::WB_DATA, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, gcpl_pkg::WB_DATA, 32'h0000_00ff);
		bus(1'b1, gcpl_pkg::WB_CTRL, 32'h1);
		cfg_rd(gcpl_pkg::IDX_VALID, 8'h20);
		cfg_rd(gcpl_pkg::IDX_PPORT, 8'h9c);
		cfg_rd(gcpl_pkg::IDX_SERIAL, 8'h08);
		cfg_rd(gcpl_pkg::IDX_RSVD3, 8'h00);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		tdone("reset values");
		for (i = 0; i < 12; i++) begin
			w = 8'($random(seed));
			p = (i == 0) ? 8'h80 : 8'($random(seed)) | 8'h80;
			misc_mode_register <= 2'($random(seed));
			cfg_wr(gcpl_pkg::IDX_VALID, w);
			cfg_rd(gcpl_pkg::IDX_VALID, exp_valid(w));
			cfg_wr(gcpl_pkg::IDX_PPORT, p);
			cfg_rd(gcpl_pkg::IDX_PPORT, exp_pport(p, 1'b1));
			cfg_wr(gcpl_pkg::IDX_SERIAL, w);
			cfg_rd(gcpl_pkg::IDX_SERIAL, exp_serial(w));
			cfg_wr(gcpl_pkg::IDX_RSVD3, w);
			cfg_rd(gcpl_pkg::IDX_RSVD3, 8'h00);
			chk({27'h0, pport_pins_en, pport_printer_mode, pport_ext_mode, serial_pins_en},
				{27'h0, p[2], p[3], p[3] ? 2'b00 : misc_mode_register, w[3]});
			pport_base_addr <= 16'($random(seed) & 32'h1ff);
			serial_base_addr <= i[0] ? 16'h00ff : 16'h0100;
			repeat (3) @(posedge clk_sys);
			chk({28'h0, pport_decode_en, pport_pnp_check, serial_decode_en, serial_pnp_check},
				{28'h0, {2{pport_base_addr >= 16'h0100}}, {2{!i[0]}}});
		end
		tdone("fields");
		cfg_wr(gcpl_pkg::IDX_PPORT, 8'h18);
		bus(1'b0, gcpl_pkg::WB_STATUS, 32'h0);
		chk({30'h0, rd[gcpl_pkg::STAT_PPORT_PWR_BIT], rd[gcpl_pkg::STAT_LOCK_BIT]}, 32'h0);
		cfg_rd(gcpl_pkg::IDX_SERIAL, 8'h00);
		cfg_wr(gcpl_pkg::IDX_PPORT, 8'h9c);
		cfg_rd(gcpl_pkg::IDX_VALID, 8'h00);
		bus(1'b0, gcpl_pkg::WB_STATUS, 32'h0);
		chk({31'h0, rd[gcpl_pkg::STAT_LOCK_BIT]}, 32'h0);
		host_bus_reset_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		host_bus_reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cfg_rd(gcpl_pkg::IDX_PPORT, 8'h98);
		cfg_rd(gcpl_pkg::IDX_SERIAL, exp_serial(w));
		tdone("lock");
		print_verdict;
	end
endmodule
`default_nettype wire
